// [design/tmr2_core.sv]
// Purpose: Sixteen-bit timer/counter with capture, reload, baud and clock-out
// Assumes: Byte register port at printed addresses; prescale from outside
// Notes: Prescale value and serial port lie outside this block
// Summary of operation
// R1 - Count clock ticks or count input falls
// R2 - Mode decoded from run and mode bits
// R3 - Timer increments once per timer clock
// R4 - Compatibility prescales except in baud and clock-out, default six clocks
// R5 - Fast mode full rate unless prescale selected
// R6 - Compatibility prescale select halves timer rate
// R7 - Baud and clock-out bypass the prescaler
// R8 - Count input sampled, high-then-low increments
// R9 - Event count at most half clock
// R10 - Source holds each level one clock
// R11 - Compatibility samples at prescaler rate
// R12 - Min 0000, max FFFF, floor from capture
// R13 - Overflow flag set unless serial clocking or clock-out
// R14 - External flag set on trigger capture/reload
// R15 - No external interrupt in up-down mode
// R16 - Overflow pulses drive selected serial clocks
// R17 - External enable gates trigger-pin events
// R18 - Run bit starts and stops counting
// R19 - Capture select picks capture or reload
// R20 - Serial and clock-out selects take priority
// R21 - Clock-out toggles count pin per overflow
// R22 - Down-count enable with external enable uses trigger as direction
// R23 - Capture copies count into capture registers
// R24 - Up overflow reloads the floor, or 0000 in capture mode
// R25 - Down underflow at floor reloads maximum
// R26 - Baud mode trigger sets flag only
// R27 - Stopped count stays readable and writable
`timescale 1ns/1ps
`include "tmr2_defs.svh"
module tmr2_core (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic compat_mode,
    input wire logic prescale_select,
    input wire logic [3:0] prescale_value,
    input wire logic timer_interrupt_enable,
    input wire logic count_input_pin_in,
    output logic count_input_pin_out,
    output logic count_input_pin_oe,
    input wire logic trigger_direction_pin,
    output logic irq,
    output logic rx_clock_pulse,
    output logic tx_clock_pulse
);
    logic [7:0] control_reg;
    logic [7:0] mode_reg;
    logic [15:0] capture_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;

    logic [3:0] presc_reg;
    logic half_reg;
    logic clkout_reg;

    logic presc_tick;
    logic tick;
    logic sample_en;
    logic cnt_fall;
    logic ex_level;
    logic ex_fall;

    logic serial_sel;
    logic count_up;
    logic at_end;
    logic rollover;
    logic ext_event;
    logic ovf_set;
    logic ext_set;
    logic ext_toggle;
    logic ext_irq_ok;
    logic step;

    tmr2_pkg::tmr2_mode_t mode;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // Compare, not equality, so a lowered divide value cannot strand the count
    function automatic logic presc_done(input logic [3:0] cnt, input logic [3:0] lim);
        presc_done = (cnt >= lim);
    endfunction

    assign serial_sel = control_reg[`TMR2_BIT_RX_SEL] | control_reg[`TMR2_BIT_TX_SEL];

    // Serial and clock-out selects outrank capture select
    always_comb begin
        if (!control_reg[`TMR2_BIT_RUN]) begin // R2 R18
            mode = tmr2_pkg::TMR2_OFF;
        end else if (mode_reg[`TMR2_BIT_OE] && !serial_sel) begin // R20
            mode = tmr2_pkg::TMR2_CLKOUT;
        end else if (serial_sel) begin // R20
            mode = tmr2_pkg::TMR2_BAUD;
        end else if (control_reg[`TMR2_BIT_CPRL]) begin // R19
            mode = tmr2_pkg::TMR2_CAPTURE;
        end else if (mode_reg[`TMR2_BIT_DOWN_EN]) begin // R22
            mode = tmr2_pkg::TMR2_UPDOWN;
        end else begin
            mode = tmr2_pkg::TMR2_RELOAD;
        end
    end

    // Prescaler divides by value plus one; compat defaults set outside
    always_ff @(posedge clk) begin
        if (!resetn) begin
            presc_reg <= 4'h0;
        end else if (presc_done(presc_reg, prescale_value)) begin
            presc_reg <= 4'h0;
        end else begin
            presc_reg <= presc_reg + 4'h1;
        end
    end
    assign presc_tick = presc_done(presc_reg, prescale_value); // R3 R4

    // Extra halving only in compatibility with select set
    // Toggle phase against the run bit is not fixed, a known limitation
    always_ff @(posedge clk) begin
        if (!resetn) begin
            half_reg <= 1'b0;
        end else if (presc_tick) begin
            half_reg <= ~half_reg;
        end
    end

    // Bypass keeps baud and clock-out rates independent of the divider
    always_comb begin
        if (mode == tmr2_pkg::TMR2_BAUD || mode == tmr2_pkg::TMR2_CLKOUT) begin
            tick = 1'b1; // R7
        end else if (compat_mode) begin
            tick = presc_tick & (~prescale_select | half_reg); // R4 R6
        end else begin
            tick = prescale_select ? presc_tick : 1'b1; // R5
        end
    end

    // Pin sampled each clock in fast mode, at prescaler rate otherwise
    assign sample_en = compat_mode ? presc_tick : 1'b1; // R8 R11

    // Only falls of the count pin matter; its level is left unused
    tmr2_edge u_count_edge (
        .clk(clk),
        .resetn(resetn),
        .pin(count_input_pin_in),
        .sample_en(sample_en),
        .level(),
        .fall(cnt_fall)
    );

    tmr2_edge u_trig_edge (
        .clk(clk),
        .resetn(resetn),
        .pin(trigger_direction_pin),
        .sample_en(sample_en),
        .level(ex_level),
        .fall(ex_fall)
    );

    // Two samples per fall caps event rate at half clock
    always_comb begin
        if (mode == tmr2_pkg::TMR2_OFF) begin
            step = 1'b0; // R18 R27
        end else if (control_reg[`TMR2_BIT_CT] && mode != tmr2_pkg::TMR2_CLKOUT) begin
            step = cnt_fall; // R1 R9
        end else begin
            step = tick; // R1 R3
        end
    end

    // Direction comes through the synchroniser, so it lags the pin by two clocks
    always_comb begin
        count_up = 1'b1;
        if (mode == tmr2_pkg::TMR2_UPDOWN && control_reg[`TMR2_BIT_EXEN]) begin
            count_up = ex_level; // R22
        end
    end

    // Up count ends at the maximum, down count at the floor
    always_comb begin
        if (count_up) begin
            at_end = (count_reg == `TMR2_CNT_MAX); // R12
        end else begin
            at_end = (count_reg == capture_reg); // R12 R25
        end
    end
    assign rollover = step & at_end;

    // In up-down mode the trigger pin is never an event; with external enable it is the direction
    always_comb begin
        ext_event = 1'b0;
        if (ex_fall && control_reg[`TMR2_BIT_EXEN]) begin // R17
            unique case (mode)
                tmr2_pkg::TMR2_OFF: ext_event = 1'b0;
                tmr2_pkg::TMR2_CAPTURE: ext_event = 1'b1; // R23
                tmr2_pkg::TMR2_RELOAD: ext_event = 1'b1; // R19
                tmr2_pkg::TMR2_UPDOWN: ext_event = 1'b0; // R22
                tmr2_pkg::TMR2_BAUD: ext_event = 1'b1; // R26
                tmr2_pkg::TMR2_CLKOUT: ext_event = 1'b1;
            endcase
        end
    end

    always_comb begin
        count_next = count_reg;
        if (step) begin
            if (!at_end) begin
                if (count_up) begin
                    count_next = count_reg + 16'h0001; // R3
                end else begin
                    count_next = count_reg - 16'h0001; // R22
                end
            end else if (!count_up) begin
                count_next = `TMR2_CNT_MAX; // R25
            end else if (mode == tmr2_pkg::TMR2_CAPTURE) begin
                count_next = `TMR2_CNT_MIN; // R12
            end else begin
                count_next = capture_reg; // R19 R24
            end
        end
        if (ext_event && (mode == tmr2_pkg::TMR2_RELOAD)) begin
            count_next = capture_reg; // R19
        end
    end

    // Software write to count wins over counting in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_reg <= {`TMR2_RST_DATA, `TMR2_RST_DATA};
        end else if (reg_wr && hit(reg_addr, `TMR2_OFS_CNT_LOW)) begin
            count_reg <= {count_reg[15:8], reg_wdata}; // R27
        end else if (reg_wr && hit(reg_addr, `TMR2_OFS_CNT_HIGH)) begin
            count_reg <= {reg_wdata, count_reg[7:0]}; // R27
        end else begin
            count_reg <= count_next;
        end
    end

    // Capture beats a software write to the capture pair
    always_ff @(posedge clk) begin
        if (!resetn) begin
            capture_reg <= {`TMR2_RST_DATA, `TMR2_RST_DATA};
        end else if (ext_event && (mode == tmr2_pkg::TMR2_CAPTURE)) begin
            capture_reg <= count_reg; // R23
        end else if (reg_wr && hit(reg_addr, `TMR2_OFS_CAP_LOW)) begin
            capture_reg <= {capture_reg[15:8], reg_wdata};
        end else if (reg_wr && hit(reg_addr, `TMR2_OFS_CAP_HIGH)) begin
            capture_reg <= {reg_wdata, capture_reg[7:0]};
        end
    end

    // Serial and clock-out rollovers are frequent and must not flood the flag
    always_comb begin
        ovf_set = rollover; // R13
        if (serial_sel) begin
            ovf_set = 1'b0; // R13
        end else if (mode == tmr2_pkg::TMR2_CLKOUT) begin
            ovf_set = 1'b0; // R21
        end
    end
    assign ext_set = ext_event; // R14 R26
    assign ext_toggle = rollover & (mode == tmr2_pkg::TMR2_UPDOWN);

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            control_reg <= `TMR2_RST_CONTROL;
        end else begin
            if (reg_wr && hit(reg_addr, `TMR2_OFS_CONTROL)) begin
                control_reg <= reg_wdata;
            end
            if (ovf_set) begin
                control_reg[`TMR2_BIT_OVF] <= 1'b1; // R13
            end
            if (ext_set) begin
                control_reg[`TMR2_BIT_EXT] <= 1'b1; // R14
            end else if (ext_toggle) begin
                control_reg[`TMR2_BIT_EXT] <= ~control_reg[`TMR2_BIT_EXT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_reg <= `TMR2_RST_MODE;
        end else if (reg_wr && hit(reg_addr, `TMR2_OFS_MODE)) begin
            // Unused mode bits dropped so they always read as zero
            mode_reg <= {6'b00_0000, reg_wdata[1:0]};
        end
    end

    // Clock-out toggles the count pin; needs timer function
    always_ff @(posedge clk) begin
        if (!resetn) begin
            clkout_reg <= 1'b0;
        end else if (rollover && mode_reg[`TMR2_BIT_OE] && !control_reg[`TMR2_BIT_CT]) begin
            clkout_reg <= ~clkout_reg; // R21
        end
    end
    // Pin drive follows the mode bits even while the timer is stopped
    assign count_input_pin_out = clkout_reg;
    assign count_input_pin_oe = mode_reg[`TMR2_BIT_OE] & ~control_reg[`TMR2_BIT_CT]; // R21

    // Up-down mode never interrupts from the external flag; it is a count bit there
    always_comb begin
        ext_irq_ok = 1'b1;
        if (mode_reg[`TMR2_BIT_DOWN_EN] && mode == tmr2_pkg::TMR2_UPDOWN) begin
            ext_irq_ok = 1'b0; // R15
        end
    end
    assign irq = timer_interrupt_enable & (control_reg[`TMR2_BIT_OVF] |
        (control_reg[`TMR2_BIT_EXT] & ext_irq_ok)); // R13 R14 R15

    // Pulses go to the serial port, which divides them further
    assign rx_clock_pulse = rollover & control_reg[`TMR2_BIT_RX_SEL]; // R16
    assign tx_clock_pulse = rollover & control_reg[`TMR2_BIT_TX_SEL]; // R16

    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            // Registered read: the address must stand one cycle before the data
            unique case (reg_addr)
                `TMR2_OFS_CONTROL: reg_rdata <= control_reg;
                `TMR2_OFS_MODE: reg_rdata <= mode_reg;
                `TMR2_OFS_CAP_LOW: reg_rdata <= capture_reg[7:0];
                `TMR2_OFS_CAP_HIGH: reg_rdata <= capture_reg[15:8];
                `TMR2_OFS_CNT_LOW: reg_rdata <= count_reg[7:0];
                `TMR2_OFS_CNT_HIGH: reg_rdata <= count_reg[15:8];
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule // tmr2_core

// [design/tmr2_defs.svh]
// Purpose: Offsets, bit positions, reset values and counts for the timer block
// Assumes: Byte-wide special register port, addresses as printed
// Notes: Included by the core and edge modules
`ifndef TMR2_DEFS_SVH
`define TMR2_DEFS_SVH
`define TMR2_OFS_CONTROL 8'hc8
`define TMR2_OFS_MODE 8'hc9
`define TMR2_OFS_CAP_LOW 8'hca
`define TMR2_OFS_CAP_HIGH 8'hcb
`define TMR2_OFS_CNT_LOW 8'hcc
`define TMR2_OFS_CNT_HIGH 8'hcd
`define TMR2_BIT_OVF 7
`define TMR2_BIT_EXT 6
`define TMR2_BIT_RX_SEL 5
`define TMR2_BIT_TX_SEL 4
`define TMR2_BIT_EXEN 3
`define TMR2_BIT_RUN 2
`define TMR2_BIT_CT 1
`define TMR2_BIT_CPRL 0
`define TMR2_BIT_OE 1
`define TMR2_BIT_DOWN_EN 0
`define TMR2_RST_CONTROL 8'h00
`define TMR2_RST_MODE 8'h00
`define TMR2_RST_DATA 8'h00
`define TMR2_CNT_MIN 16'h0000
`define TMR2_CNT_MAX 16'hffff
`define TMR2_PRESCALE_DEFAULT 4'h5
`endif

// [design/tmr2_pkg.sv]
// Purpose: Types shared by the timer block
// Assumes: Constants live in the defs header
// Notes: Mode codes are one-hot
package tmr2_pkg;
    typedef enum logic [5:0] {
        TMR2_OFF = 6'b00_0001,
        TMR2_CAPTURE = 6'b00_0010,
        TMR2_RELOAD = 6'b00_0100,
        TMR2_UPDOWN = 6'b00_1000,
        TMR2_BAUD = 6'b01_0000,
        TMR2_CLKOUT = 6'b10_0000
    } tmr2_mode_t;
endpackage

// [design/tmr2_edge.sv]
// Purpose: Two-stage synchroniser with falling-edge detector
// Assumes: Asynchronous pin input, one system clock
// Notes: Edge is found between two sample-enabled samples
`timescale 1ns/1ps
`include "tmr2_defs.svh"
module tmr2_edge (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pin,
    input wire logic sample_en,
    output logic level,
    output logic fall
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
        end
    end
    // Sample held between enables so slow sampling still sees each level
    always_ff @(posedge clk) begin
        if (!resetn) begin
            last_reg <= 1'b0;
        end else if (sample_en) begin
            last_reg <= sync_reg;
        end
    end
    assign level = sync_reg;
    assign fall = sample_en & last_reg & ~sync_reg;
endmodule // tmr2_edge

// [tb/tmr2_asserts.sv]
// Purpose: Port-level assertions for the timer block
// Assumes: Bound to tmr2_core, one clock domain
// Notes: Shadows follow software writes; hardware flags are not tracked
`timescale 1ns/1ps
module tmr2_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic timer_interrupt_enable,
    input wire logic count_input_pin_out,
    input wire logic count_input_pin_oe,
    input wire logic irq,
    input wire logic rx_clock_pulse,
    input wire logic tx_clock_pulse
);
    logic [7:0] ctl_reg;
    logic oe_reg;
    always_ff @(posedge clk) begin
        if (!resetn) ctl_reg <= 8'h00;
        else if (reg_wr && reg_addr == 8'hc8) ctl_reg <= reg_wdata;
    end
    always_ff @(posedge clk) begin
        if (!resetn) oe_reg <= 1'b0;
        else if (reg_wr && reg_addr == 8'hc9) oe_reg <= reg_wdata[1];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_mode_wr;
        reg_wr && reg_addr == 8'hc9 ##1 reg_addr == 8'hc9;
    endsequence
    // Three cycles are margin only; the pulses are combinational
    sequence s_stopped;
        !ctl_reg[2] [*3];
    endsequence
    AST_MODE_RB: assert property (s_mode_wr |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 2))
        else $error("mode bits read back wrong");
    AST_MODE_HI: assert property (reg_addr == 8'hc9 |=> reg_rdata[7:2] == 6'h00)
        else $error("unused mode bits not zero");
    AST_UNMAPPED: assert property (!(reg_addr inside {[8'hc8:8'hcd]}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_OE: assert property (count_input_pin_oe == (oe_reg && !ctl_reg[1]))
        else $error("pin drive enable wrong");
    AST_CLKOUT: assert property ($changed(count_input_pin_out) |-> $past(count_input_pin_oe))
        else $error("pin toggled while not driven");
    AST_RX: assert property (rx_clock_pulse |-> ctl_reg[5] || $past(ctl_reg[5]))
        else $error("receive pulse without select");
    AST_TX: assert property (tx_clock_pulse |-> ctl_reg[4] || $past(ctl_reg[4]))
        else $error("transmit pulse without select");
    AST_IRQ: assert property (irq |-> timer_interrupt_enable)
        else $error("interrupt while disabled");
    AST_STOP: assert property (s_stopped |-> !rx_clock_pulse && !tx_clock_pulse)
        else $error("pulse while stopped");
endmodule // tmr2_asserts
bind tmr2_core tmr2_asserts chk_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .timer_interrupt_enable(timer_interrupt_enable), .count_input_pin_out(count_input_pin_out),
    .count_input_pin_oe(count_input_pin_oe), .irq(irq), .rx_clock_pulse(rx_clock_pulse),
    .tx_clock_pulse(tx_clock_pulse));

// [tb/tmr2_pins.sv]
// Purpose: Event source for count input and trigger pins
// Assumes: Bench asks for levels
// Notes: A change asked too early is deferred, dropped if withdrawn first
`timescale 1ns/1ps
module tmr2_pins (
    input wire logic clk,
    input wire logic cnt_want,
    input wire logic trg_want,
    input wire logic [3:0] min_hold,
    output logic cnt_pin,
    output logic trg_pin
);
    logic [3:0] age_reg = 4'hf;
    initial begin
        cnt_pin = 1'b1;
        trg_pin = 1'b1;
    end
    always @(posedge clk) begin
        if ({cnt_want, trg_want} != {cnt_pin, trg_pin} && age_reg >= min_hold) begin
            cnt_pin <= cnt_want;
            trg_pin <= trg_want;
            age_reg <= 4'h1;
        end else if (age_reg != 4'hf) begin
            age_reg <= age_reg + 4'h1;
        end
    end
endmodule // tmr2_pins

// [tb/timer2_reload_capture_unit_bench.sv]
// Purpose: Register-level tests of the timer block
// Assumes: Pins come from the pin model
// Notes: Rate checks allow two counts of prescaler phase slack
`timescale 1ns/1ps
module timer2_reload_capture_unit_bench;
    logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, cm = 1'b0, ps = 1'b0, ie = 1'b0;
    logic cw = 1'b1, tw = 1'b1, po = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, v;
    logic [3:0] pv = 4'h5, hold = 4'h1;
    logic [15:0] w, w2;
    logic cp, tp, out, oe, irq, rxp, txp, pin;
    int bad_count = 0, comparisons = 0, cyc = 0, np = 0, nt = 0, nx = 0, n0, t0, x0;
    logic rc [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic rs [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [3:0] rv [4] = '{4'h0, 4'h3, 4'h5, 4'h5};
    int rn [4] = '{40, 40, 118, 238};
    logic [15:0] re [4] = '{16'h002a, 16'h000a, 16'h0014, 16'h0014};
    always #10 clk = ~clk;
    assign pin = oe ? out : cp;
    tmr2_core dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(rdata), .compat_mode(cm), .prescale_select(ps),
        .prescale_value(pv), .timer_interrupt_enable(ie), .count_input_pin_in(pin),
        .count_input_pin_out(out), .count_input_pin_oe(oe), .trigger_direction_pin(tp),
        .irq(irq), .rx_clock_pulse(rxp), .tx_clock_pulse(txp));
    tmr2_pins src (.clk(clk), .cnt_want(cw), .trg_want(tw), .min_hold(hold),
        .cnt_pin(cp), .trg_pin(tp));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        np <= np + int'(rxp === 1'b1);
        nx <= nx + int'(txp === 1'b1);
        nt <= nt + int'(out !== po);
        po <= out;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Prescaler phase is unknown to the bench
    task automatic near(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if ((^g) === 1'bx || g + 16'h0002 < e || g > e + 16'h0002) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1 d = rdata;
    endtask
    task automatic w16(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 8'h01, d[15:8]);
    endtask
    task automatic r16(input logic [7:0] a, output logic [15:0] d);
        rd(a, d[7:0]);
        rd(a + 8'h01, d[15:8]);
    endtask
    task automatic clicks(input int n);
        repeat (n) begin
            @(posedge clk) cw <= 1'b0;
            repeat (hold) @(posedge clk);
            cw <= 1'b1;
            repeat (hold - 4'h1) @(posedge clk);
        end
        repeat (14) @(posedge clk);
    endtask
    task automatic trig();
        @(posedge clk) tw <= 1'b0;
        repeat (8) @(posedge clk);
        tw <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        ie <= 1'b1;
        rd(8'hc8, v); chk(v, 8'h00);
        rd(8'hc9, v); chk(v, 8'h00);
        rd(8'hc7, v); chk(v, 8'h00);
        wr(8'hc9, 8'hff); rd(8'hc9, v); chk(v, 8'h03);
        wr(8'hc9, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) cm <= rc[i];
            ps <= rs[i];
            pv <= rv[i];
            w16(8'hcc, 16'h0000);
            wr(8'hc8, 8'h04);
            repeat (rn[i]) @(posedge clk);
            wr(8'hc8, 8'h00);
            r16(8'hcc, w); near(w, re[i]);
            repeat (8) @(posedge clk);
            r16(8'hcc, w2); chk(w2, w);
        end
        $display("test rates done");
        for (int j = 0; j < 2; j++) begin
            @(posedge clk) cm <= j[0];
            hold <= j[0] ? 4'h6 : 4'h1;
            w16(8'hcc, 16'h0000);
            wr(8'hc8, 8'h06);
            clicks(8);
            r16(8'hcc, w); chk(w, 16'h0008);
        end
        @(posedge clk) cm <= 1'b0;
        hold <= 4'h1;
        $display("test events done");
        w16(8'hcc, 16'h1234);
        wr(8'hc8, 8'h0f);
        trig();
        r16(8'hca, w); chk(w, 16'h1234);
        rd(8'hc8, v); chk(v, 8'h4f);
        chk(irq, 1'b1);
        w16(8'hca, 16'h0000);
        wr(8'hc8, 8'h07);
        trig();
        r16(8'hca, w); chk(w, 16'h0000);
        rd(8'hc8, v); chk(v, 8'h07);
        w16(8'hca, 16'habcd);
        wr(8'hc8, 8'h0e);
        trig();
        r16(8'hcc, w); chk(w, 16'habcd);
        rd(8'hc8, v); chk(v, 8'h4e);
        $display("test capture done");
        w16(8'hcc, 16'hffff);
        wr(8'hc8, 8'h06);
        clicks(1);
        r16(8'hcc, w); chk(w, 16'habcd);
        rd(8'hc8, v); chk(v, 8'h86);
        chk(irq, 1'b1);
        @(posedge clk) ie <= 1'b0;
        @(posedge clk) #1 chk(irq, 1'b0);
        @(posedge clk) tw <= 1'b0;
        ie <= 1'b1;
        w16(8'hca, 16'h2000);
        w16(8'hcc, 16'h2000);
        wr(8'hc9, 8'h01);
        wr(8'hc8, 8'h0e);
        clicks(1);
        r16(8'hcc, w); chk(w, 16'hffff);
        rd(8'hc8, v); chk(v, 8'hce);
        wr(8'hc8, 8'h4e);
        rd(8'hc8, v); chk(irq, 1'b0);
        @(posedge clk) tw <= 1'b1;
        wr(8'hc9, 8'h00);
        $display("test reload done");
        @(posedge clk) cm <= 1'b1;
        ps <= 1'b1;
        w16(8'hca, 16'hfff0);
        w16(8'hcc, 16'hfff0);
        wr(8'hc9, 8'h02);
        wr(8'hc8, 8'h3c);
        n0 = np;
        t0 = nt;
        x0 = nx;
        repeat (160) @(posedge clk);
        near(16'(np - n0), 16'h000a);
        near(16'(nx - x0), 16'h000a);
        near(16'(nt - t0), 16'h000a);
        trig();
        rd(8'hc8, v); chk(v, 8'h7c);
        wr(8'hc8, 8'h04);
        t0 = nt;
        repeat (160) @(posedge clk);
        near(16'(nt - t0), 16'h000a);
        rd(8'hc8, v); chk(v, 8'h04);
        wr(8'hc8, 8'h00);
        wr(8'hc9, 8'h00);
        $display("test baud done");
        summarize();
    end
endmodule // timer2_reload_capture_unit_bench
